// File: include/igs_pkg.sv
`default_nettype none
// ************************************************************
// Shared constants for the drive and joystick select glue
// ************************************************************
package igs_pkg;
    // Host I/O address width (A9..A0)
    localparam int IGS_AW = 10;
    // Drive command block bases, eight addresses each
    localparam logic [9:0] IGS_PRI_CMD = 10'h1F0;
    localparam logic [9:0] IGS_SEC_CMD = 10'h170;
    // Drive 8-bit mode range, four addresses
    localparam logic [9:0] IGS_XT_CMD = 10'h320;
    // Drive control block pairs
    localparam logic [9:0] IGS_PRI_CTRL = 10'h3F6;
    localparam logic [9:0] IGS_SEC_CTRL = 10'h376;
    // Joystick port address
    localparam logic [9:0] IGS_GAME_ADDR = 10'h201;
    // Register byte offsets on the Wishbone side
    localparam logic [3:0] IGS_CTRL_OFS = 4'h0;
    localparam logic [3:0] IGS_STAT_OFS = 4'h4;
    // Control register fields and reset value
    localparam int IGS_CTRL_W = 5;
    localparam int IGS_EN_BIT = 0;
    localparam int IGS_MODE16_BIT = 1;
    localparam int IGS_SEC_BIT = 2;
    localparam int IGS_ADAPT_BIT = 3;
    localparam int IGS_GAME_BIT = 4;
    localparam logic [4:0] IGS_CTRL_RST = 5'h1B;
    // Status register fields
    localparam int IGS_STRAP_W = 5;
    localparam int IGS_PV_BIT = 5;
    localparam int IGS_WIDE_BIT = 6;
    localparam int IGS_DACK_BIT = 7;
    // Strap vector positions
    localparam int IGS_SER0_BIT = 0;
    localparam int IGS_SER1_BIT = 1;
    localparam int IGS_DRV_BIT = 2;
    localparam int IGS_FLOP_BIT = 3;
    localparam int IGS_PAR_BIT = 4;
endpackage : igs_pkg
`default_nettype wire

// File: hdl/igs_addr_decode.sv
`default_nettype none
// ************************************************************
// Host address decode, purely combinational
// ************************************************************
module igs_addr_decode
    import igs_pkg::*;
(
    input wire logic [IGS_AW-1:0] addr_i,
    input wire logic mode16_i,
    input wire logic sec_i,
    output logic cmd_hit_o,
    output logic ctrl_first_o,
    output logic ctrl_second_o,
    output logic game_hit_o
);
    // Selected bases for the active address set
    wire logic [9:0] cmd_base = sec_i ? IGS_SEC_CMD : IGS_PRI_CMD;
    // 8-bit mode always uses the primary control pair
    wire logic [9:0] ctrl_base = (mode16_i && sec_i) ? IGS_SEC_CTRL : IGS_PRI_CTRL;
    wire logic cmd16_hit = (addr_i[9:3] == cmd_base[9:3]);
    wire logic cmd8_hit = (addr_i[9:2] == IGS_XT_CMD[9:2]);
    wire logic ctrl_hit = (addr_i[9:1] == ctrl_base[9:1]);

    // Eight addresses in 16-bit mode, four in 8-bit mode
    assign cmd_hit_o = mode16_i ? cmd16_hit : cmd8_hit;
    assign ctrl_first_o = ctrl_hit && !addr_i[0];
    assign ctrl_second_o = ctrl_hit && addr_i[0];
    assign game_hit_o = (addr_i == IGS_GAME_ADDR);
endmodule // igs_addr_decode
`default_nettype wire

// File: hdl/igs_d7_path.sv
`default_nettype none
// ************************************************************
// Data bit 7 steering between host and drive
// ************************************************************
module igs_d7_path (
    input wire logic mode16_i,
    input wire logic active_i,
    input wire logic cmd_hit_i,
    input wire logic ctrl_first_i,
    input wire logic ctrl_second_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic host_d7_i,
    input wire logic drive_d7_i,
    input wire logic disk_change_i,
    output logic host_d7_o,
    output logic host_oe_n_o,
    output logic drive_d7_o,
    output logic drive_oe_n_o
);
    // Path only exists in 16-bit mode with the drive enabled
    wire logic on = active_i && mode16_i;
    wire logic rd_pass = on && rd_i && (cmd_hit_i || ctrl_first_i);
    wire logic rd_chg = on && rd_i && ctrl_second_i;
    // Second control address is write-only toward the drive
    wire logic wr_pass = on && wr_i && (cmd_hit_i || ctrl_first_i || ctrl_second_i);

    // Disk-change flag replaces drive bit on that one read
    assign host_d7_o = rd_chg ? disk_change_i : drive_d7_i;
    assign host_oe_n_o = !(rd_pass || rd_chg);
    assign drive_d7_o = host_d7_i;
    assign drive_oe_n_o = !wr_pass;
endmodule // igs_d7_path
`default_nettype wire

// File: hdl/igs_top.sv
// Notes on behaviour
// - High-byte enable goes low only in 16-bit mode, with the wide qualifier active, inside the command range.
// - Command-block select covers eight addresses in 16-bit mode and the four-address range in 8-bit mode.
// - Control-block select covers the selected control pair in 16-bit mode and the primary pair in 8-bit mode.
// - In 16-bit mode bit 7 passes both ways for commands and first control address, drive-ward on second.
// - In 16-bit mode a host read of the second control address returns the floppy disk-change flag as bit 7.
// - With power-good low host inputs and register writes are ignored and the pads float and idle; the Wishbone slave still acks and returns reads.
// - Register contents stay unchanged while power-good is low.
// - In adapter configuration the joystick select goes low at the joystick address.
// - In adapter configuration the straps are sampled while reset is high and then held.
// - With the drive enabled the low-byte enable covers commands and control in 16-bit mode, or range and DMA in 8-bit.
`default_nettype none
module igs_top
    import igs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Host I/O side
    input wire logic [IGS_AW-1:0] io_addr_i,
    input wire logic io_rd_n_i,
    input wire logic io_wr_n_i,
    input wire logic power_valid_i,
    input wire logic wide_select_qualifier_i,
    input wire logic wide_transfer_ind_n_i,
    input wire logic disk_change_i,
    input wire logic host_d7_i,
    output logic host_d7_o,
    output logic host_d7_oe_n_o,
    // Strap inputs
    input wire logic serial_strap0_i,
    input wire logic serial_strap1_i,
    input wire logic drive_addr_strap_i,
    input wire logic floppy_addr_strap_i,
    input wire logic parport_mode_strap_i,
    output logic [IGS_STRAP_W-1:0] straps_o,
    // Drive side
    input wire logic drive_data_bit7_i,
    output logic drive_data_bit7_o,
    output logic drive_data_bit7_oe_n_o,
    output logic drive_high_byte_enable_n_o,
    output logic drive_low_byte_enable_n_o,
    output logic disk_cmd_block_select_n_o,
    output logic disk_ctrl_block_select_n_o,
    output logic joystick_select_n_o,
    output logic outputs_float_o
);

    // ************************************************************
    // Configuration register
    // ************************************************************

    logic [IGS_CTRL_W-1:0] ctrl_reg;
    logic [IGS_STRAP_W-1:0] strap_reg;
    logic ack_reg;

    wire logic drive_en = ctrl_reg[IGS_EN_BIT];
    wire logic mode16 = ctrl_reg[IGS_MODE16_BIT];
    wire logic sec_set = ctrl_reg[IGS_SEC_BIT];
    wire logic adapter = ctrl_reg[IGS_ADAPT_BIT];
    wire logic game_en = ctrl_reg[IGS_GAME_BIT];

    // Inputs count only while power is valid
    wire logic pv = power_valid_i;
    wire logic active = pv && drive_en;
    wire logic io_rd = !io_rd_n_i;
    wire logic io_wr = !io_wr_n_i;
    // Same pin, two meanings depending on mode
    wire logic wide_req = mode16 && !wide_transfer_ind_n_i;
    wire logic dma_ack = !mode16 && !wide_transfer_ind_n_i;

    // ************************************************************
    // Address decode and bit 7 path
    // ************************************************************

    logic cmd_hit;
    logic ctrl_first;
    logic ctrl_second;
    logic game_hit;

    igs_addr_decode u_dec (
        .addr_i(io_addr_i),
        .mode16_i(mode16),
        .sec_i(sec_set),
        .cmd_hit_o(cmd_hit),
        .ctrl_first_o(ctrl_first),
        .ctrl_second_o(ctrl_second),
        .game_hit_o(game_hit)
    );

    logic d7_host;
    logic d7_host_oe_n;
    logic d7_drive;
    logic d7_drive_oe_n;

    igs_d7_path u_d7 (
        .mode16_i(mode16),
        .active_i(active),
        .cmd_hit_i(cmd_hit),
        .ctrl_first_i(ctrl_first),
        .ctrl_second_i(ctrl_second),
        .rd_i(io_rd),
        .wr_i(io_wr),
        .host_d7_i(host_d7_i),
        .drive_d7_i(drive_data_bit7_i),
        .disk_change_i(disk_change_i),
        .host_d7_o(d7_host),
        .host_oe_n_o(d7_host_oe_n),
        .drive_d7_o(d7_drive),
        .drive_oe_n_o(d7_drive_oe_n)
    );

    // ************************************************************
    // Next values of the select outputs
    // ************************************************************

    // Hits are gated by enable and power before the flops
    wire logic ctrl_hit = ctrl_first || ctrl_second;
    wire logic hi_next_n = !(active && mode16 && wide_select_qualifier_i && cmd_hit);
    wire logic cmd_next_n = !(active && cmd_hit);
    wire logic ctl_next_n = !(active && ctrl_hit);
    // 8-bit mode also enables the low byte on a DMA acknowledge
    wire logic lo_next_n = !(active && (mode16 ? (cmd_hit || ctrl_hit) : (cmd_hit || dma_ack)));
    wire logic game_next_n = !(pv && adapter && game_en && game_hit);

    // ************************************************************
    // Registered select outputs
    // ************************************************************

    // One flop of latency: 20 ns is well inside a host I/O cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_high_byte_enable_n_o <= 1'b1;
            drive_low_byte_enable_n_o <= 1'b1;
            disk_cmd_block_select_n_o <= 1'b1;
            disk_ctrl_block_select_n_o <= 1'b1;
            joystick_select_n_o <= 1'b1;
        end else if (ce_i) begin
            drive_high_byte_enable_n_o <= hi_next_n;
            drive_low_byte_enable_n_o <= lo_next_n;
            disk_cmd_block_select_n_o <= cmd_next_n;
            disk_ctrl_block_select_n_o <= ctl_next_n;
            joystick_select_n_o <= game_next_n;
        end
    end

    // Bit 7 pin drivers; enables high means released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_d7_o <= 1'b0;
            host_d7_oe_n_o <= 1'b1;
            drive_data_bit7_o <= 1'b0;
            drive_data_bit7_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            host_d7_o <= d7_host;
            host_d7_oe_n_o <= d7_host_oe_n;
            drive_data_bit7_o <= d7_drive;
            drive_data_bit7_oe_n_o <= d7_drive_oe_n;
        end
    end

    // Pad drivers go high-impedance while power is bad
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            outputs_float_o <= 1'b0;
        end else if (ce_i) begin
            outputs_float_o <= !pv;
        end
    end

    // ************************************************************
    // Strap capture
    // ************************************************************

    wire logic [IGS_STRAP_W-1:0] strap_pins = {
        parport_mode_strap_i,
        floppy_addr_strap_i,
        drive_addr_strap_i,
        serial_strap1_i,
        serial_strap0_i
    };

    // Sampled on every enabled edge while reset is high and power is valid, held afterwards
    always_ff @(posedge clk_i) begin
        if (ce_i && rst_i && IGS_CTRL_RST[IGS_ADAPT_BIT] && pv) begin
            strap_reg <= strap_pins;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            straps_o <= '0;
        end else if (ce_i) begin
            straps_o <= strap_reg;
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************

    wire logic bus_req = wb_cyc_i && wb_stb_i;
    wire logic ack_next = bus_req && !ack_reg;
    wire logic hit_ctrl = (wb_adr_i == IGS_CTRL_OFS);
    wire logic hit_stat = (wb_adr_i == IGS_STAT_OFS);
    // Writes land at the edge that ends the ack cycle; dropped while power is bad so contents survive
    wire logic ctrl_we = bus_req && ack_reg && wb_we_i && wb_sel_i[0] && hit_ctrl && pv;

    wire logic [7:0] stat_word = {dma_ack, wide_req, pv, strap_reg};
    // Unmapped offsets still answer, with zero data
    wire logic [31:0] rd_next = hit_ctrl ? {27'h000_0000, ctrl_reg} :
                                hit_stat ? {24'h00_0000, stat_word} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= IGS_CTRL_RST;
        end else if (ce_i && ctrl_we) begin
            ctrl_reg <= wb_dat_i[IGS_CTRL_W-1:0];
        end
    end

    // Answer one cycle after the request, for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= ack_next;
            wb_dat_o <= rd_next;
        end
    end

    assign wb_ack_o = ack_reg;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    hi_byte_a: assert property (ce_i && pv && drive_en && mode16 && wide_select_qualifier_i && cmd_hit
        |=> !drive_high_byte_enable_n_o) else $error("high byte enable missed");

    hi_byte_xt_a: assert property (ce_i && !mode16 |=> drive_high_byte_enable_n_o)
        else $error("high byte enable in 8-bit mode");

    cmd_select_a: assert property (ce_i |=> disk_cmd_block_select_n_o == !$past(active && cmd_hit))
        else $error("command select wrong");

    ctrl_select_a: assert property (ce_i && active && io_addr_i == IGS_PRI_CTRL && !(mode16 && sec_set)
        |=> !disk_ctrl_block_select_n_o) else $error("control select missed");

    low_byte_a: assert property (ce_i && active && !mode16 && !wide_transfer_ind_n_i
        |=> !drive_low_byte_enable_n_o) else $error("low byte on DMA missed");

    low_byte16_a: assert property (ce_i && active && mode16 && (cmd_hit || ctrl_first || ctrl_second)
        |=> !drive_low_byte_enable_n_o) else $error("low byte enable missed");

    d7_read_a: assert property (ce_i && active && mode16 && io_rd && cmd_hit
        |=> !host_d7_oe_n_o && host_d7_o == $past(drive_data_bit7_i)) else $error("bit 7 read path");

    drive_write_a: assert property (ce_i && active && mode16 && io_wr && ctrl_second
        |=> !drive_data_bit7_oe_n_o && drive_data_bit7_o == $past(host_d7_i)) else $error("bit 7 write path");

    change_read_a: assert property (ce_i && active && mode16 && io_rd && ctrl_second
        |=> host_d7_o == $past(disk_change_i)) else $error("disk change not returned");

    float_out_a: assert property (ce_i && !pv |=> outputs_float_o && disk_cmd_block_select_n_o
        && host_d7_oe_n_o && drive_data_bit7_oe_n_o) else $error("outputs not floated");

    regs_hold_a: assert property (!pv |=> $stable(ctrl_reg))
        else $error("register changed without power");

    game_select_a: assert property (ce_i && pv && adapter && game_en && io_addr_i == IGS_GAME_ADDR
        |=> !joystick_select_n_o) else $error("joystick select missed");

    game_off_a: assert property (ce_i && !(pv && adapter && game_en) |=> joystick_select_n_o)
        else $error("joystick select without adapter");

    strap_hold_a: assert property (!rst_i |=> $stable(strap_reg))
        else $error("straps changed after reset");

    bus_ack_a: assert property (bus_req && !ack_reg && ce_i |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
        else $error("ack timing wrong");

    // A low clock enable must leave settings and selects untouched
    frozen_state_a: assert property (!ce_i |=> $stable(ctrl_reg) && $stable(joystick_select_n_o)
        && $stable(disk_cmd_block_select_n_o)) else $error("state moved while frozen");

endmodule // igs_top
`default_nettype wire

// File: tb/igs_drive_model.sv
`default_nettype none
// ************************************************************
// Drive end of the disk cable, bit 7 and shared 16-bit pin
// ************************************************************
module igs_drive_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_sel_n_i,
    input wire logic ctrl_sel_n_i,
    input wire logic io_rd_n_i,
    input wire logic dut_d7_i,
    input wire logic dut_d7_oe_n_i,
    input wire logic data_i,
    input wire logic req_i,
    output logic d7_o,
    output logic wide_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg;
    logic drive_on;
    // Drive answers only while selected and read strobe is low
    assign drive_on = !io_rd_n_i && (!cmd_sel_n_i || !ctrl_sel_n_i);
    // Released line shows the inverse of its last level, so stale data never passes
    assign d7_o = !dut_d7_oe_n_i ? dut_d7_i : (drive_on ? data_i : ~last_reg);
    // Low asks for 16-bit transfers, or acknowledges DMA in 8-bit mode
    assign wide_n_o = ~req_i;
    // Remember the wire level for the released state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= d7_o;
        end
    end
endmodule // igs_drive_model
`default_nettype wire

// File: tb/test_ide_game_select_decode.sv
`default_nettype none
// ************************************************************
// Bench for the drive and joystick select glue
// ************************************************************
module test_ide_game_select_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import igs_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, rd_n, wr_n, pv, qual, req, dchg, hb, dbit, ce;
    logic [3:0] adr;
    logic [9:0] addr;
    logic [4:0] strap, straps_q;
    logic [31:0] wdat, wb_q, rd_q;
    logic wb_ack, host_o, host_oe_n, host_in, drv_o, drv_oe_n, drv_in, wide_n;
    logic hi_n, lo_n, cmd_n, ctrl_n, joy_n, float_o;
    wire logic [4:0] sel_v = {hi_n, lo_n, cmd_n, ctrl_n, joy_n};
    int error_cnt, checks;
    logic [9:0] alist [21] = '{10'h1EF, 10'h1F0, 10'h1F7, 10'h1F8, 10'h16F, 10'h170, 10'h177, 10'h178, 10'h3F5,
        10'h3F6, 10'h3F7, 10'h3F8, 10'h375, 10'h376, 10'h377, 10'h31F, 10'h320, 10'h323, 10'h324, 10'h201, 10'h200};
    logic [4:0] clist [4] = '{5'h1B, 5'h1F, 5'h19, 5'h0A};
    // Host owns bit 7 unless the block drives it
    assign host_in = host_oe_n ? hb : host_o;
    igs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
        .io_addr_i(addr), .io_rd_n_i(rd_n), .io_wr_n_i(wr_n), .power_valid_i(pv),
        .wide_select_qualifier_i(qual), .wide_transfer_ind_n_i(wide_n), .disk_change_i(dchg),
        .host_d7_i(host_in), .host_d7_o(host_o), .host_d7_oe_n_o(host_oe_n), .serial_strap0_i(strap[0]),
        .serial_strap1_i(strap[1]), .drive_addr_strap_i(strap[2]), .floppy_addr_strap_i(strap[3]),
        .parport_mode_strap_i(strap[4]), .straps_o(straps_q), .drive_data_bit7_i(drv_in),
        .drive_data_bit7_o(drv_o), .drive_data_bit7_oe_n_o(drv_oe_n), .drive_high_byte_enable_n_o(hi_n),
        .drive_low_byte_enable_n_o(lo_n), .disk_cmd_block_select_n_o(cmd_n),
        .disk_ctrl_block_select_n_o(ctrl_n), .joystick_select_n_o(joy_n), .outputs_float_o(float_o));
    igs_drive_model u_drive (.clk_i(clk_i), .rst_i(rst_i), .cmd_sel_n_i(cmd_n), .ctrl_sel_n_i(ctrl_n),
        .io_rd_n_i(rd_n), .dut_d7_i(drv_o), .dut_d7_oe_n_i(drv_oe_n), .data_i(dbit), .req_i(req),
        .d7_o(drv_in), .wide_n_o(wide_n));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Classic single cycle; holds the request until ack, only the watchdog ends a hung wait
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rd_q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // One host access; three edges cover decode, drive answer and bit 7 capture
    task automatic io(input logic [9:0] a, input logic r, w, b, q, d);
        @(posedge clk_i);
        addr <= a;
        rd_n <= r;
        wr_n <= w;
        hb <= b;
        qual <= q;
        req <= d;
        repeat (3) @(posedge clk_i);
    endtask
    // Bit 7 steering: e is {host oe_n, host bit, drive oe_n, drive bit}
    task automatic d7(input logic [9:0] a, input logic r, w, b, db, dc, input logic [3:0] e);
        dbit <= db;
        dchg <= dc;
        io(a, r, w, b, 1'b1, 1'b0);
        chk("host bit7 enable", host_oe_n, e[3]);
        if (!e[3]) chk("host bit7", host_o, e[2]);
        chk("drive bit7 enable", drv_oe_n, e[1]);
        if (!e[1]) chk("drive bit7", drv_o, e[0]);
    endtask
    // Expected {high, low, cmd, ctrl, joystick}, all active low
    function automatic logic [4:0] exp_sel(input logic [9:0] a, input logic [4:0] c, input logic q, d);
        logic [9:0] cb, kb;
        logic cmd, ctl, lo, hi;
        cb = c[IGS_SEC_BIT] ? IGS_SEC_CMD : IGS_PRI_CMD;
        kb = c[IGS_SEC_BIT] ? IGS_SEC_CTRL : IGS_PRI_CTRL;
        if (c[IGS_MODE16_BIT]) begin
            cmd = a >= cb && a <= cb + 10'h007;
            ctl = a == kb || a == kb + 10'h001;
            lo = cmd || ctl;
            hi = cmd && q;
        end else begin
            cmd = a >= IGS_XT_CMD && a <= IGS_XT_CMD + 10'h003;
            ctl = a == IGS_PRI_CTRL || a == IGS_PRI_CTRL + 10'h001;
            lo = cmd || d;
            hi = 1'b0;
        end
        if (!c[IGS_EN_BIT]) {hi, lo, cmd, ctl} = 4'h0;
        return ~{hi, lo, cmd, ctl, a == IGS_GAME_ADDR && c[IGS_ADAPT_BIT] && c[IGS_GAME_BIT]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // Clock, watchdog and test sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {cyc, stb, we, adr, wdat, addr} = '0;
        // Strobes idle high and power valid, so straps are captured during reset
        {ce, rd_n, wr_n, pv, qual, req, dchg, hb, dbit} = 9'h1E0;
        strap = 5'b10110;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        strap <= 5'b01001;
        repeat (3) @(posedge clk_i);
        chk("straps", straps_q, 5'b10110);
        wb(1'b0, IGS_CTRL_OFS, 32'h0);
        chk("ctrl reset", rd_q, 32'h0000_001B);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", rd_q, 32'h0000_0000);
        wb(1'b1, IGS_CTRL_OFS, 32'hFFFF_FFE4);
        wb(1'b0, IGS_CTRL_OFS, 32'h0);
        chk("ctrl width", rd_q, 32'h0000_0004);
        // Address sweep across every mode and address set
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, IGS_CTRL_OFS, 32'(clist[k]));
            for (int i = 0; i < 21; i++) begin
                io(alist[i], 1'b1, 1'b1, 1'b0, i[0], i[1]);
                chk("selects", sel_v, exp_sel(alist[i], clist[k], i[0], i[1]));
            end
        end
        // Shared pin seen as 16-bit request, then as DMA acknowledge
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_001B);
        io(10'h000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        wb(1'b0, IGS_STAT_OFS, 32'h0);
        chk("status wide", rd_q, 32'h0000_0076);
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_0019);
        wb(1'b0, IGS_STAT_OFS, 32'h0);
        chk("status dack", rd_q, 32'h0000_00B6);
        // Bit 7 steering in 16-bit mode
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_001B);
        d7(10'h1F0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'b0110);
        d7(10'h3F6, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'b0010);
        d7(10'h3F7, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'b0110);
        d7(10'h3F7, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'b0010);
        d7(10'h1F3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'b1001);
        d7(10'h3F6, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'b1000);
        d7(10'h3F7, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'b1001);
        d7(10'h300, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'b1010);
        // Path stays off in 8-bit mode
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_0019);
        d7(10'h320, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'b1010);
        d7(10'h3F7, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'b1010);
        // Clock enable low freezes the selects, then they follow again
        ce <= 1'b0;
        io(IGS_GAME_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("frozen joystick", joy_n, 1'b1);
        ce <= 1'b1;
        io(IGS_GAME_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("joystick 8-bit", joy_n, 1'b0);
        // Power drop: everything floats, settings and straps survive
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_001B);
        pv <= 1'b0;
        io(IGS_PRI_CMD, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        chk("float", float_o, 1'b1);
        chk("idle pins", {hi_n, lo_n, cmd_n, ctrl_n, joy_n, host_oe_n, drv_oe_n}, 7'h7F);
        wb(1'b1, IGS_CTRL_OFS, 32'h0000_0000);
        pv <= 1'b1;
        io(IGS_GAME_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("float off", float_o, 1'b0);
        chk("joystick back", joy_n, 1'b0);
        wb(1'b0, IGS_CTRL_OFS, 32'h0);
        chk("ctrl kept", rd_q, 32'h0000_001B);
        chk("straps kept", straps_q, 5'b10110);
        wrap_up();
    end
endmodule // test_ide_game_select_decode
`default_nettype wire
